// *** hdl/scd_clock_divider.sv ***
// Contract
// R1: Divide sample clock by integer ratio 1 through 8 for conversion clock.
// R2: Any ratio other than one forces the stabiliser on.
// R3: A valid sync pulse returns the divider to its initial state.
// R4: Register bits 1 and 2 pick sync on every pulse or first pulse.
// R5: Locked stabiliser keeps rising edge and regenerates falling edge at 50%.
// R6: Stabiliser loop is not relied on below a nominal 20 MHz input; the code has no rate check and uses the stabiliser at any input rate.
// R7: Relock takes 1.5 to 5 us after any input frequency change.
// R8: While unlocked the stabiliser is bypassed and raw duty cycle passes.
// R9: Reference sense level decodes to four reference modes.
// R10: Software should keep the stabiliser enabled unless rate changes.
// R11: Samples are taken on the rising edge of the conversion clock.
// R12: First-pulse mode arms on register write and disarms after realignment.
//
// Top of the sample clock block: divider, sync, stabiliser and reference
// decode. The sample clock arrives as a pin sampled by clk_in, so it must be
// well below 20 MHz here; the comparator levels arrive already digitised.
`timescale 1ns/1ps
module scd_clock_divider #(
  parameter int unsigned LOCK_WAIT = scd_pkg::LOCK_CYCLES
) (
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 sample_clk_in,
  input  wire logic                 sync_in,
  input  wire logic                 reg_wr_in,
  input  wire logic [8:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  output logic      [7:0]           reg_rdata_out,
  input  wire logic [2:0]           div_code_in,
  input  wire logic                 dcs_enable_in,
  input  wire logic                 rate_change_in,
  input  wire logic                 sense_above_0v2_in,
  input  wire logic                 sense_at_ref_in,
  input  wire logic                 sense_at_supply_in,
  output logic                      conv_clk_out,
  output logic                      sample_strobe_out,
  output logic                      dcs_active_out,
  output logic                      dcs_locked_out,
  output scd_pkg::scd_ref_mode_t    ref_mode_out,
  output logic                      internal_ref_en_out
);
  import scd_pkg::*;

  if (LOCK_WAIT < 1) begin : g_lock_wait_check
    $error("LOCK_WAIT must be at least one cycle");
  end

  logic       clk_s;
  logic       sync_s;
  logic       clk_d;
  logic       sync_d;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic       armed;
  logic       next_armed;
  logic       prev_raw;
  logic [2:0] rise_cnt;
  logic [2:0] next_rise_cnt;
  logic       raw_div;
  logic       next_raw_div;
  logic       stab;
  logic       next_stab;
  logic [15:0] per;
  logic [15:0] next_per;
  logic [15:0] hi_cnt;
  logic [15:0] next_hi_cnt;
  logic [15:0] half;
  logic [15:0] next_half;
  logic [31:0] lock_cnt;
  logic [31:0] next_lock_cnt;
  logic       locked;
  logic       next_locked;
  logic       rise;
  logic       sync_rise;
  logic       sync_fire;
  logic       reg_hit;
  logic       dcs_on;
  logic [2:0] div_m1;

  scd_sync3 u_clk_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (sample_clk_in),
    .q_out     (clk_s)
  );

  scd_sync3 u_sync_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (sync_in),
    .q_out     (sync_s)
  );

  // Divide code n selects ratio n+1, so every ratio 1..8 is reachable.
  assign div_m1    = div_code_in; // R1
  assign rise      = clk_s & ~clk_d;
  assign sync_rise = sync_s & ~sync_d;
  assign reg_hit   = reg_wr_in && (reg_addr_in == CLOCK_SYNC_CONTROL_ADDR);
  // Sync acts when enabled; in one-shot mode only while armed.
  assign sync_fire = sync_rise && ctrl[SYNC_ENABLE_BIT] &&
                     (!ctrl[SYNC_ONESHOT_BIT] || armed); // R4
  assign dcs_on    = dcs_enable_in || (div_m1 != 3'h0); // R2

  always_comb begin
    next_ctrl = reg_hit ? reg_wdata_in : ctrl;
    // A write re-arms even if a sync fires in the same cycle.
    if (reg_hit) begin
      next_armed = 1'b1; // R12
    end else if (sync_fire && ctrl[SYNC_ONESHOT_BIT]) begin
      next_armed = 1'b0; // R12
    end else begin
      next_armed = armed;
    end
  end

  // Divider: a counter of input rising edges; output toggles around count.
  always_comb begin
    next_rise_cnt = rise_cnt;
    next_raw_div  = raw_div;
    if (sync_fire) begin
      next_rise_cnt = 3'h0; // R3
      next_raw_div  = 1'b0; // R3
    end else if (rise_cnt > div_m1) begin
      // Lowering the ratio can strand the count past its new end point.
      next_rise_cnt = 3'h0; // R1
    end else if (rise) begin
      if (rise_cnt == div_m1) begin
        next_rise_cnt = 3'h0;
        next_raw_div  = 1'b1; // R11
      end else begin
        next_rise_cnt = rise_cnt + 3'h1;
        if (rise_cnt == (div_m1 >> 1)) begin
          next_raw_div = 1'b0;
        end
      end
    end
    if (div_m1 == 3'h0) begin
      next_raw_div = clk_s;
    end
  end

  // Stabiliser: measure the divided period, keep the rising edge and drop
  // the output after half a period. Lock needs a stable period for a while.
  always_comb begin
    next_per      = per;
    next_half     = half;
    next_hi_cnt   = (hi_cnt != 16'hffff) ? hi_cnt + 16'h1 : hi_cnt;
    next_stab     = stab;
    next_lock_cnt = lock_cnt;
    next_locked   = locked;
    if (raw_div && !prev_raw) begin
      next_per    = hi_cnt;
      next_half   = hi_cnt >> 1;
      next_hi_cnt = 16'h1;
      next_stab   = 1'b1; // R5
    end else if (stab && hi_cnt >= half) begin
      next_stab = 1'b0; // R5
    end
    if (rate_change_in || !dcs_on || sync_fire) begin
      next_lock_cnt = 32'h0; // R7
      next_locked   = 1'b0;
    end else if (raw_div && !prev_raw) begin
      if (hi_cnt != per) begin
        next_lock_cnt = 32'h0; // R7
        next_locked   = 1'b0;
      end else if (lock_cnt >= LOCK_WAIT - 1) begin
        next_locked = 1'b1; // R7
      end else begin
        next_lock_cnt = lock_cnt + 32'h1;
      end
    end else if (!locked && lock_cnt < LOCK_WAIT - 1) begin
      next_lock_cnt = lock_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_d    <= 1'b0;
      sync_d   <= 1'b0;
      ctrl     <= CLOCK_SYNC_CONTROL_RST;
      armed    <= 1'b0;
      rise_cnt <= 3'h0;
      raw_div  <= 1'b0;
      prev_raw <= 1'b0;
      stab     <= 1'b0;
      per      <= 16'h0;
      half     <= 16'h0;
      hi_cnt   <= 16'h0;
      lock_cnt <= 32'h0;
      locked   <= 1'b0;
    end else begin
      clk_d    <= clk_s;
      sync_d   <= sync_s;
      ctrl     <= next_ctrl;
      armed    <= next_armed;
      rise_cnt <= next_rise_cnt;
      raw_div  <= next_raw_div;
      prev_raw <= raw_div;
      stab     <= next_stab;
      per      <= next_per;
      half     <= next_half;
      hi_cnt   <= next_hi_cnt;
      lock_cnt <= next_lock_cnt;
      locked   <= next_locked;
    end
  end

  // Bypass the stabiliser until locked so timing follows the raw duty.
  assign conv_clk_out      = (dcs_on && locked) ? stab : raw_div; // R8
  assign sample_strobe_out = raw_div & ~prev_raw; // R11
  assign dcs_active_out    = dcs_on;
  assign dcs_locked_out    = locked;
  assign reg_rdata_out     = ctrl;

  // Reference sense decode, supply level taking precedence.
  always_comb begin
    if (sense_at_supply_in) begin
      ref_mode_out = SCD_REF_EXTERNAL; // R9
    end else if (sense_at_ref_in) begin
      ref_mode_out = SCD_REF_FIXED_0V5; // R9
    end else if (sense_above_0v2_in) begin
      ref_mode_out = SCD_REF_PROGRAMMED; // R9
    end else begin
      ref_mode_out = SCD_REF_FIXED_1V0; // R9
    end
  end
  assign internal_ref_en_out = (ref_mode_out != SCD_REF_EXTERNAL);

  AST_FORCE_DCS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (div_code_in != 3'h0) |-> dcs_active_out) // R2
    else $error("stabiliser not forced on for ratio above one");
  AST_SYNC_RESET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    sync_fire |=> (rise_cnt == 3'h0)) // R3
    else $error("divider not realigned by sync");
  AST_ONESHOT_DISARM: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    (sync_fire && ctrl[SYNC_ONESHOT_BIT] && !reg_hit) |=> !armed) // R12
    else $error("one-shot sync did not disarm");
  AST_WRITE_ARMS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_hit |=> (armed && ctrl == $past(reg_wdata_in))) // R4
    else $error("register write did not arm or store");
  AST_BYPASS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !locked |-> (conv_clk_out == raw_div)) // R8
    else $error("stabiliser not bypassed while unlocked");
  AST_UNLOCK_ON_CHANGE: assert property (@(posedge clk_in)
    disable iff (!arst_n_in) rate_change_in |=> !locked) // R7
    else $error("lock kept after rate change");
  AST_DIV_RANGE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rise_cnt <= div_m1 || $changed(div_code_in)) // R1
    else $error("divider count out of range");
  AST_REF_EXT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    sense_at_supply_in |-> !internal_ref_en_out) // R9
    else $error("internal reference left on in external mode");
endmodule

// *** include/scd_pkg.sv ***
// Package for the sample clock divider, sync and duty cycle stabiliser block.
// Assumes a single 40 MHz system clock and an active-low asynchronous reset.
package scd_pkg;
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned CLK_PERIOD_PS     = 25_000;
  // Register map.
  localparam logic [8:0]  CLOCK_SYNC_CONTROL_ADDR = 9'h100;
  localparam logic [7:0]  CLOCK_SYNC_CONTROL_RST  = 8'h00;
  localparam int unsigned SYNC_ENABLE_BIT   = 1;
  localparam int unsigned SYNC_ONESHOT_BIT  = 2;
  // Divider.
  localparam int unsigned DIV_MIN           = 1;
  localparam int unsigned DIV_MAX           = 8;
  localparam logic [2:0]  DIV_CODE_RST      = 3'h0;
  // Stabiliser lock timing, in nanoseconds as printed (1.5 us and 5 us).
  localparam int unsigned LOCK_MIN_NS       = 1500;
  localparam int unsigned LOCK_MAX_NS       = 5000;
  localparam int unsigned LOCK_CYCLES       =
    (LOCK_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Lowest input rate at which the stabiliser loop works, in MHz.
  localparam int unsigned DCS_MIN_MHZ       = 20;
  // Reference modes.
  typedef enum logic [1:0] {
    SCD_REF_FIXED_1V0   = 2'b00,
    SCD_REF_FIXED_0V5   = 2'b01,
    SCD_REF_PROGRAMMED  = 2'b10,
    SCD_REF_EXTERNAL    = 2'b11
  } scd_ref_mode_t;
endpackage

// *** hdl/scd_sync3.sv ***
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ps
module scd_sync3 (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       q;
  logic       next_q;

  always_comb begin
    next_stage = {stage[1:0], d_in};
    // The first stage only feeds the second; filtering looks at 2 and 3.
    next_q     = (stage[1] == stage[2]) ? stage[1] : q;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage <= 3'h0;
      q     <= 1'b0;
    end else begin
      stage <= next_stage;
      q     <= next_q;
    end
  end

  assign q_out = q;
endmodule

// *** sim/scd_clk_src.sv ***
// Far-side model: free-running raw sample clock and sync pin source.
// Assumes clk_in is the 40 MHz bench clock; the raw clock is slower.
`timescale 1ns/1ps
module scd_clk_src #(
  parameter int unsigned HI = 2,
  parameter int unsigned LO = 6
) (
  input  wire logic clk_in,
  input  wire logic sync_req_in,
  output logic      sample_clk_out,
  output logic      sync_out
);
  int unsigned cnt = 0;
  // A 25% duty raw clock makes stabiliser retiming visible at the output.
  initial sample_clk_out = 1'b0;
  always @(negedge clk_in) begin
    cnt            <= (cnt == HI + LO - 1) ? 0 : cnt + 1;
    sample_clk_out <= (cnt < HI);
  end
  // The sync level is held for many raw periods, so one pulse per request.
  assign sync_out = sync_req_in;
endmodule

// *** sim/scd_clock_divider_tb_top.sv ***
// Bench for the sample clock divider: ratios, sync modes, stabiliser, ref.
// Assumes scd_clk_src as far side and LOCK_WAIT shortened to 4.
`timescale 1ns/1ps
module scd_clock_divider_tb_top;
  import scd_pkg::*;
  logic clk = 0, arst_n = 0, wr = 0, dcs_en = 0, rchg = 0, sreq = 0;
  logic s02 = 0, sref = 0, ssup = 0, raw, sync_w, cclk, stb, act, lck, iref;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [2:0] code = 3'h0;
  scd_ref_mode_t rmode;
  int bad_count = 0, n_compared = 0, cyc = 0;
  int da, db, dc, dd, d, r, s, cr;
  logic [3:0] pat [4] = '{4'h0, 4'h4, 4'h6, 4'h7};
  logic [1:0] mode [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  always #12.5 clk = ~clk;
  scd_clk_src src (.clk_in(clk), .sync_req_in(sreq), .sample_clk_out(raw),
    .sync_out(sync_w));
  scd_clock_divider #(.LOCK_WAIT(4)) dut (.clk_in(clk), .arst_n_in(arst_n),
    .sample_clk_in(raw), .sync_in(sync_w), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .div_code_in(code), .dcs_enable_in(dcs_en), .rate_change_in(rchg),
    .sense_above_0v2_in(s02), .sense_at_ref_in(sref),
    .sense_at_supply_in(ssup), .conv_clk_out(cclk), .sample_strobe_out(stb),
    .dcs_active_out(act), .dcs_locked_out(lck), .ref_mode_out(rmode),
    .internal_ref_en_out(iref));
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] v);
    @(negedge clk);
    wr = 1; addr = a; wdata = v;
    @(negedge clk);
    wr = 0;
  endtask
  // Cycles from raising sync to the next strobe, after shift raw edges.
  task automatic sync_delay(input int shift, output int dl);
    repeat (shift) @(posedge raw);
    @(negedge clk);
    sreq = 1; dl = 0;
    // A strobe in the first four cycles comes before the sync can act.
    while ((stb !== 1'b1 || dl < 5) && dl < 200) begin
      @(posedge clk); #1; dl++;
    end
    @(negedge clk);
    sreq = 0;
    repeat (8) @(negedge clk);
  endtask
  task automatic hi_len(output int n);
    n = 0;
    while (cclk !== 1'b0 && n < 100) begin @(posedge clk); #1; n++; end
    n = 0;
    while (cclk !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
    n = 0;
    while (cclk === 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
  endtask
  task automatic wait_lock;
    int n;
    n = 0;
    while (lck !== 1'b1 && n < 400) begin @(posedge clk); #1; n++; end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin bad_count++; close_out; end
  end
  initial begin
    repeat (8) @(negedge clk);
    check("rst_rdata", rdata, CLOCK_SYNC_CONTROL_RST);
    check("rst_conv", {7'h0, cclk}, 8'h00);
    arst_n = 1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {s02, sref, ssup} = pat[i][2:0];
      #1 check("ref_mode", {6'h0, rmode}, {6'h0, mode[i]});
      check("iref_en", {7'h0, iref}, {7'h0, (i != 3)});
    end
    wr_reg(9'h0ff, 8'h06);
    check("unmapped", rdata, 8'h00);
    for (int c = 0; c < 8; c++) begin
      @(negedge clk);
      code = c[2:0];
      repeat (32) @(negedge clk);
      check("dcs_forced", {7'h0, act}, {7'h0, (c != 0)});
      r = cclk; s = 0; cr = 0;
      repeat (768) begin
        @(posedge clk); #1;
        s += stb;
        cr += (cclk && !r);
        r = cclk;
      end
      check("ratio", {7'h0, (s >= 96 / (c + 1) - 1 && s <= 96 / (c + 1) + 1)},
        8'h01);
      check("strobe_rise", {7'h0, (cr - s <= 1 && s - cr <= 1)}, 8'h01);
    end
    // Ratio one with the stabiliser off shows the raw two-cycle high time.
    @(negedge clk);
    code = 3'h0;
    hi_len(d);
    check("raw_duty", d[7:0], 8'h02);
    @(negedge clk);
    code = 3'h7;
    wr_reg(CLOCK_SYNC_CONTROL_ADDR, 8'h02);
    check("rdata", rdata, 8'h02);
    sync_delay(2, da);
    sync_delay(5, db);
    check("sync_every", db[7:0], da[7:0]);
    wr_reg(CLOCK_SYNC_CONTROL_ADDR, 8'h00);
    sync_delay(2, dc);
    sync_delay(5, dd);
    check("sync_off", {7'h0, (dc != dd)}, 8'h01);
    wr_reg(CLOCK_SYNC_CONTROL_ADDR, 8'h06);
    sync_delay(2, dc);
    sync_delay(5, dd);
    check("first_acts", dc[7:0], da[7:0]);
    check("second_ign", {7'h0, (dd != da)}, 8'h01);
    wr_reg(CLOCK_SYNC_CONTROL_ADDR, 8'h06);
    sync_delay(5, dd);
    check("rearmed", dd[7:0], da[7:0]);
    @(negedge clk);
    code = 3'h0;
    dcs_en = 1;
    // The lock from ratio eight must first drop on the new period.
    repeat (16) @(negedge clk);
    wait_lock;
    hi_len(d);
    check("dcs_duty", d[7:0], 8'h04);
    @(negedge clk);
    rchg = 1;
    @(negedge clk);
    rchg = 0;
    @(negedge clk);
    check("lock_drop", {7'h0, lck}, 8'h00);
    wait_lock;
    check("relock", {7'h0, lck}, 8'h01);
    close_out;
  end
endmodule
